// ==== design/tcc_pkg.sv ====
package tcc_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CNT_LO = 6'h00;
  localparam logic [5:0] OFS_CNT_HI = 6'h04;
  localparam logic [5:0] OFS_PORT_DATA = 6'h08;
  localparam logic [5:0] OFS_PORT_DIR = 6'h0C;
  localparam logic [5:0] OFS_CTRL = 6'h10;
  localparam logic [5:0] OFS_CMP_DATA = 6'h14;
  localparam logic [5:0] OFS_CMP_DIR = 6'h18;
  localparam logic [5:0] OFS_FLAG = 6'h1C;
  localparam logic [5:0] OFS_FLAG_EN = 6'h20;

  // Control register fields.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CS = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_OSC = 3;
  localparam int CTRL_PS_LSB = 4;
  localparam int CTRL_PS_MSB = 5;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Shared port: the two pins sit at bits 2:1 of the port registers.
  localparam int PORT_LSB = 1;
  localparam int PORT_MSB = 2;
  localparam logic [1:0] PORT_DIR_RST = 2'h3;
  localparam logic [1:0] PORT_DATA_RST = 2'h0;
  localparam logic CMP_DIR_RST = 1'b1;
  localparam logic FW_BIT_RST = 1'b0;

  // Count and prescaler.
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [2:0] PS_RST = 3'h0;

  // The instruction cycle is four periods of clk.
  localparam int CLK_HZ = 40_000_000;
  localparam int INSTR_CLKS = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);

endpackage : tcc_pkg

// ==== design/tcc_timer.sv ====
// Summary of operation
// - Sixteen-bit count, two bytes, read and write.
// - Wrap from all ones raises overflow.
// - Run bit starts and stops counting.
// - Timer mode counts instruction cycles.
// - Counter mode counts external rising edges.
// - Timer, synced counter, unsynced counter modes.
// - Oscillator enable forces both pins input.
// - Compare trigger clears the count.
// - Prescale field divides by one, two, four, eight.
// - Timer mode, oscillator off: pins normal I/O.
// - Clock pin input: count pin, read pin.
// - Clock pin output: firmware bit clocks count.
// - Counter mode clock port bit read rules.
// - Back to timer: pin driven from latch.
// - Oscillator mode: crystal clocks, firmware bit zero.
// - Oscillator mode: both port bits read rules.
// - Source and oscillator clear: latches drive pins.
// - Software count write beats compare trigger.
// - Compare trigger reset never sets overflow flag.
// - Overflow latched in flag, gated by enable.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic osc_run,
  input wire logic cmp_trigger,
  output logic overflow_event,
  output logic overflow_irq
);

  logic ack_q;
  logic [31:0] readdata_q;
  logic [7:0] ctrl_q;
  logic [15:0] cnt_q;
  logic [2:0] ps_q;
  logic [1:0] instr_q;
  logic [1:0] port_latch_q;
  logic [1:0] port_dir_q;
  logic fw_q;
  logic cmp_dir_q;
  logic flag_q;
  logic flag_en_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic lvl1_q;
  logic lvl2_q;
  logic [1:0] pin_out_q;
  logic [1:0] pin_oe_q;
  logic ovf_evt_q;
  logic irq_q;

  // Bus handshake: one wait cycle, then the access completes.
  wire req = read | write;
  wire wr_go = write & ack_q & byteenable[0];
  wire rd_load = read & ~ack_q;
  wire sel_lo = address == tcc_pkg::OFS_CNT_LO;
  wire sel_hi = address == tcc_pkg::OFS_CNT_HI;
  wire sel_pd = address == tcc_pkg::OFS_PORT_DATA;
  wire sel_pr = address == tcc_pkg::OFS_PORT_DIR;
  wire sel_ct = address == tcc_pkg::OFS_CTRL;
  wire sel_cd = address == tcc_pkg::OFS_CMP_DATA;
  wire sel_cr = address == tcc_pkg::OFS_CMP_DIR;
  wire sel_fl = address == tcc_pkg::OFS_FLAG;
  wire sel_fe = address == tcc_pkg::OFS_FLAG_EN;
  wire wr_lo = wr_go & sel_lo;
  wire wr_hi = wr_go & sel_hi;
  wire wr_cnt = wr_lo | wr_hi;
  wire [7:0] wbyte = writedata[7:0];

  // Mode decode.
  wire run = ctrl_q[tcc_pkg::CTRL_RUN];
  wire cs = ctrl_q[tcc_pkg::CTRL_CS];
  wire osc = ctrl_q[tcc_pkg::CTRL_OSC];
  wire bypass = ctrl_q[tcc_pkg::CTRL_SYNC];
  wire [1:0] ps_code = ctrl_q[tcc_pkg::CTRL_PS_MSB:tcc_pkg::CTRL_PS_LSB];
  wire fw_mode = cs & ~osc & ~cmp_dir_q;

  wire count_lvl = fw_mode ? fw_q : pin_s2_q[0];
  wire edge_fast = count_lvl & ~lvl1_q;
  wire edge_slow = lvl1_q & ~lvl2_q;
  wire ext_tick = bypass ? edge_fast : edge_slow;
  wire instr_tick = instr_q == tcc_pkg::INSTR_LAST;
  wire src_tick = cs ? ext_tick : instr_tick;

  wire [2:0] ps_limit = 3'((4'h1 << ps_code) - 4'h1);
  wire ps_done = ps_q == ps_limit;
  wire inc = run & src_tick & ps_done;
  wire trig = cmp_trigger & ~wr_cnt;
  wire ovf_set = inc & (cnt_q == tcc_pkg::COUNT_MAX) & ~wr_cnt & ~trig;

  logic [15:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt) begin
      if (wr_lo) begin
        cnt_d[7:0] = wbyte;
      end
      if (wr_hi) begin
        cnt_d[15:8] = wbyte;
      end
    end else if (trig) begin
      cnt_d = tcc_pkg::COUNT_RST;
    end else if (inc) begin
      cnt_d = 16'(cnt_q + 16'h0001);
    end
  end

  wire [2:0] ps_d = (trig | ~run) ? tcc_pkg::PS_RST :
    (run & src_tick) ? (ps_done ? tcc_pkg::PS_RST : 3'(ps_q + 3'h1)) : ps_q;

  wire flag_d = ovf_set | (flag_q & ~(wr_go & sel_fl & wbyte[0]));

  // Shared pin control and read-back, per pin.
  logic [1:0] port_rd;
  logic [1:0] pin_out_d;
  logic [1:0] pin_oe_d;
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_pin
      wire claimed = osc | ((k == 0) & cs);
      wire fw_drive = (k == 0) & fw_mode;
      assign port_rd[k] = claimed ? (port_dir_q[k] ? 1'b0 : port_latch_q[k]) :
        (port_dir_q[k] ? pin_s2_q[k] : port_latch_q[k]);
      assign pin_oe_d[k] = osc ? 1'b0 : (claimed ? fw_drive : ~port_dir_q[k]);
      assign pin_out_d[k] = fw_drive ? fw_q : port_latch_q[k];
    end
  endgenerate

  wire fw_rd = osc ? 1'b0 : ((cs & cmp_dir_q) ? pin_s2_q[0] : fw_q);

  wire [7:0] rd_mux =
    sel_lo ? cnt_q[7:0] :
    sel_hi ? cnt_q[15:8] :
    sel_pd ? {5'h00, port_rd, 1'b0} :
    sel_pr ? {5'h00, port_dir_q, 1'b0} :
    sel_ct ? (ctrl_q & tcc_pkg::CTRL_MASK) :
    sel_cd ? {7'h00, fw_rd} :
    sel_cr ? {7'h00, cmp_dir_q} :
    sel_fl ? {7'h00, flag_q} :
    sel_fe ? {7'h00, flag_en_q} : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (rd_load) begin
        readdata_q <= {24'h000000, rd_mux};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= tcc_pkg::CTRL_RST;
      port_latch_q <= tcc_pkg::PORT_DATA_RST;
      port_dir_q <= tcc_pkg::PORT_DIR_RST;
      fw_q <= tcc_pkg::FW_BIT_RST;
      cmp_dir_q <= tcc_pkg::CMP_DIR_RST;
      flag_en_q <= 1'b0;
    end else begin
      if (wr_go & sel_ct) begin
        ctrl_q <= wbyte & tcc_pkg::CTRL_MASK;
      end
      if (wr_go & sel_pd) begin
        port_latch_q <= wbyte[tcc_pkg::PORT_MSB:tcc_pkg::PORT_LSB];
      end
      if (wr_go & sel_pr) begin
        port_dir_q <= wbyte[tcc_pkg::PORT_MSB:tcc_pkg::PORT_LSB];
      end
      if (wr_go & sel_cd & ~osc) begin
        fw_q <= wbyte[0];
      end
      if (wr_go & sel_cr) begin
        cmp_dir_q <= wbyte[0];
      end
      if (wr_go & sel_fe) begin
        flag_en_q <= wbyte[0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= tcc_pkg::COUNT_RST;
      ps_q <= tcc_pkg::PS_RST;
      instr_q <= 2'h0;
      flag_q <= 1'b0;
      ovf_evt_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ps_q <= ps_d;
      instr_q <= 2'(instr_q + 2'h1);
      flag_q <= flag_d;
      ovf_evt_q <= ovf_set;
      irq_q <= flag_d & flag_en_q;
    end
  end

  // Pins are synchronized by two flip-flops before any use.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      lvl1_q <= 1'b0;
      lvl2_q <= 1'b0;
      pin_out_q <= 2'h0;
      pin_oe_q <= 2'h0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      lvl1_q <= count_lvl;
      lvl2_q <= lvl1_q;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = req & ~ack_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign osc_run = osc;
  assign overflow_event = ovf_evt_q;
  assign overflow_irq = irq_q;

  a_ovf_sets_flag: assert property (@(posedge clk) disable iff (!nrst)
    ovf_set |=> flag_q && overflow_event && cnt_q == tcc_pkg::COUNT_RST)
    else $error("overflow did not set flag");

  a_trig_no_flag: assert property (@(posedge clk) disable iff (!nrst)
    cmp_trigger && !wr_cnt && !flag_q |=> !flag_q && !overflow_event)
    else $error("trigger reset set the overflow flag");

  a_trig_clears: assert property (@(posedge clk) disable iff (!nrst)
    cmp_trigger && !wr_cnt |=> cnt_q == tcc_pkg::COUNT_RST)
    else $error("trigger did not clear count");

  a_write_wins: assert property (@(posedge clk) disable iff (!nrst)
    wr_lo && cmp_trigger |=> cnt_q[7:0] == $past(wbyte))
    else $error("trigger overrode count write");

  a_stop_holds: assert property (@(posedge clk) disable iff (!nrst)
    !run && !wr_cnt && !cmp_trigger |=> $stable(cnt_q))
    else $error("count moved while stopped");

  a_timer_rate: assert property (@(posedge clk) disable iff (!nrst)
    (run && !cs && ps_code == 2'h0 && !wr_cnt && !cmp_trigger)[*5]
      |-> cnt_q != $past(cnt_q, 4))
    else $error("timer missed an instruction cycle");

  a_osc_pins_in: assert property (@(posedge clk) disable iff (!nrst)
    osc |=> pin_oe == 2'h0)
    else $error("pin driven in oscillator mode");

  a_fw_drives: assert property (@(posedge clk) disable iff (!nrst)
    fw_mode |=> pin_oe[0] && pin_out[0] == $past(fw_q))
    else $error("firmware bit not on clock pin");

  a_latch_drives: assert property (@(posedge clk) disable iff (!nrst)
    !cs && !osc |=> pin_oe == ~$past(port_dir_q) && pin_out == $past(port_latch_q))
    else $error("pins not driven from latches");

  a_div_eight: assert property (@(posedge clk) disable iff (!nrst)
    inc && ps_code == 2'h3 |-> ps_q == 3'h7)
    else $error("divide by eight counted early");

  a_ctrl_rsvd: assert property (@(posedge clk) disable iff (!nrst)
    rd_load && sel_ct |=> readdata[7:6] == 2'h0 && readdata[31:8] == 24'h000000)
    else $error("reserved control bits not zero");

endmodule : tcc_timer

`default_nettype wire

// ==== bench/tcc_xclk.sv ====
`timescale 1ns/1ps
`default_nettype none

module tcc_xclk (
  input wire logic clk,
  input wire logic en,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_in
);
  logic [2:0] cnt_q = 3'h0;

  // The clock stands still while disabled, and the crystal sides swing opposite.
  always @(posedge clk) begin
    if (en) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  assign pin_in[0] = pin_oe[0] ? pin_out[0] : cnt_q[2];
  assign pin_in[1] = pin_oe[1] ? pin_out[1] : ~cnt_q[2];
endmodule : tcc_xclk

`default_nettype wire

// ==== bench/tb_sixteen_bit_timer_counter.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_sixteen_bit_timer_counter;
  typedef struct {logic [7:0] e; logic [7:0] t; string n;} tcc_note_t;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [5:0] address = 6'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic cmp_trigger = 1'h0;
  logic xen = 1'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic osc_run;
  logic overflow_event;
  logic overflow_irq;
  int num_errors = 0;
  int tests_run = 0;
  int events = 0;
  tcc_note_t notes[$];
  tcc_note_t cur;

  always #12.5 clk = ~clk;

  tcc_timer DUT (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .osc_run(osc_run),
    .cmp_trigger(cmp_trigger), .overflow_event(overflow_event), .overflow_irq(overflow_irq));
  tcc_xclk PARTNER (.clk(clk), .en(xen), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] t, input logic [31:0] s);
    tests_run++;
    if (!((s[31:8] === 24'h0) && ((s[7:0] - e <= t) === 1'h1))) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // The trigger, when asked for, lands in the completing cycle of the request.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic trg);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
      cmp_trigger <= trg & waitrequest;
    end while (waitrequest);
    write <= 1'h0;
    read <= 1'h0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'h1, a, d, 1'h0);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] t, input string n);
    notes.push_back('{e, t, n});
    bus(1'h0, a, 8'h00, 1'h0);
  endtask : rd

  task automatic fw(input int k);
    repeat (k) begin
      wr(6'h14, 8'h01);
      wr(6'h14, 8'h00);
    end
    repeat (4) @(posedge clk);
  endtask : fw

  task automatic xrun(input int k);
    @(posedge clk);
    xen <= 1'h1;
    repeat (8 * k) @(posedge clk);
    xen <= 1'h0;
    repeat (8) @(posedge clk);
  endtask : xrun

  always @(posedge clk) begin
    if (nrst && read && !waitrequest) begin
      cur = notes.pop_front();
      chk(cur.n, cur.e, cur.t, readdata);
    end
    if (overflow_event === 1'h1) begin
      events++;
    end
  end

  task automatic report_and_stop;
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #1ms;
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [7:0] r;
    void'($urandom(32'h0818A5F1));
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    rd(6'h10, 8'h00, 8'h00, "ctrl");
    rd(6'h3C, 8'h00, 8'h00, "unmapped");
    wr(6'h10, 8'hC4);
    rd(6'h10, 8'h04, 8'h00, "ctrl_mask");
    r = 8'($urandom());
    wr(6'h00, r);
    wr(6'h04, ~r);
    rd(6'h00, r, 8'h00, "count_lo");
    rd(6'h04, ~r, 8'h00, "count_hi");
    wr(6'h18, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(6'h10, 8'h00);
      wr(6'h00, 8'h00);
      wr(6'h10, 8'(p * 16 + (p % 2) * 4 + 3));
      fw(8);
      rd(6'h00, 8'h08 >> p, 8'h00, "prescale");
    end
    wr(6'h20, 8'h01);
    wr(6'h10, 8'h00);
    wr(6'h04, 8'hFF);
    wr(6'h00, 8'hFE);
    wr(6'h10, 8'h03);
    fw(2);
    chk("events", 8'h01, 8'h00, 32'(events));
    chk("irq", 8'h01, 8'h00, {31'h0, overflow_irq});
    rd(6'h1C, 8'h01, 8'h00, "flag");
    rd(6'h04, 8'h00, 8'h00, "wrap_hi");
    wr(6'h1C, 8'h01);
    rd(6'h1C, 8'h00, 8'h00, "flag_clear");
    wr(6'h0C, 8'h00);
    wr(6'h14, 8'h01);
    rd(6'h14, 8'h01, 8'h00, "fw_bit");
    chk("pin_fw", 8'h01, 8'h00, {31'h0, pin_out[0]});
    wr(6'h10, 8'h00);
    repeat (3) @(posedge clk);
    chk("pin_oe", 8'h03, 8'h00, {30'h0, pin_oe});
    chk("pin_latch", 8'h00, 8'h00, {30'h0, pin_out});
    wr(6'h04, 8'hFF);
    @(posedge clk);
    cmp_trigger <= 1'h1;
    @(posedge clk);
    cmp_trigger <= 1'h0;
    rd(6'h04, 8'h00, 8'h00, "trig_clear");
    rd(6'h1C, 8'h00, 8'h00, "trig_flag");
    bus(1'h1, 6'h00, 8'h5A, 1'h1);
    rd(6'h00, 8'h5A, 8'h00, "write_wins");
    wr(6'h00, 8'h00);
    wr(6'h10, 8'h01);
    repeat (400) @(posedge clk);
    wr(6'h10, 8'h00);
    rd(6'h00, 8'h64, 8'h01, "timer");
    wr(6'h18, 8'h01);
    wr(6'h0C, 8'h02);
    wr(6'h08, 8'h06);
    for (int s = 0; s < 2; s++) begin
      wr(6'h10, 8'h00);
      wr(6'h00, 8'h00);
      wr(6'h10, 8'(s * 4 + 3));
      xrun(5);
      rd(6'h00, 8'h05, 8'h00, "ext_count");
    end
    rd(6'h14, 8'h00, 8'h00, "pin_level");
    rd(6'h08, 8'h04, 8'h00, "port_cnt");
    wr(6'h10, 8'h00);
    wr(6'h00, 8'h00);
    wr(6'h10, 8'h0B);
    wr(6'h14, 8'h01);
    xrun(3);
    chk("osc_oe", 8'h04, 8'h00, {29'h0, osc_run, pin_oe});
    rd(6'h14, 8'h00, 8'h00, "osc_fw");
    rd(6'h00, 8'h03, 8'h00, "osc_count");
    rd(6'h08, 8'h04, 8'h00, "osc_port");
    wr(6'h10, 8'h00);
    repeat (3) @(posedge clk);
    chk("pins_back", 8'h0B, 8'h00, {28'h0, pin_oe, pin_out});
    report_and_stop();
  end
endmodule : tb_sixteen_bit_timer_counter

`default_nettype wire
